// *** hw/wuf_device.sv ***
/*
 * wuf_device: device end of one wide serial channel: register file, transmit
 * FIFO, receive pipeline and FIFO, pixel packing and the receive chain DMA.
 * Assumes: the host holds each target request until t_ack and drops it the
 * cycle after; host memory answers each master request with one m_ack pulse.
 */
// Implementation choice: the APB slave port.
//
// Operation
// R1: descriptor is three consecutive longwords, fetched in order
// R2: chain addresses used directly as bus addresses
// R3: host gives byte lengths in whole longwords
// R4: writing zero to pointer aborts receive chain
// R5: host sets end-of-chain only in last next-pointer
// R6: host sets direction one in every pointer
// R7: read-only receive word count at 0xC
// R8: count reaches FIFO depth plus four
// R9: port write pushes transmit, read pops receive
// R10: port-read word never reaches later DMA
// R11: two 14-bit pixels per word, top bits dropped
// R12: pixel field order swappable each direction
// R13: frame marker sets bit 15 or 31
// R14: transmit low water when count below threshold
// R15: only low threshold bits are compared
// R16: receive high water when count reaches threshold
// R17: receive comparison includes pipeline words
// R18: pointer holds address, direction, end-of-chain bits
// R19: fetch descriptors, follow next-pointers until end-of-chain
// R20: descriptor holds buffer, length, next-pointer
// R21: high water latch stays until written one
// R22: empty port read changes nothing
`timescale 1ns/100ps
`default_nettype none
module wuf_device (
	input  wire logic              I_SYS_CLK,
	input  wire logic              I_RESET,
	wuf_link_if.dev                link,
	input  wire logic              I_RX_PIX_VALID,
	input  wire logic [13:0]       I_RX_PIX,
	input  wire logic              I_RX_FRAME,
	input  wire logic              I_TX_READY,
	output logic                   O_TX_VALID,
	output logic      [31:0]       O_TX_WORD,
	output logic                   O_TX_LOW_WATER,
	output logic                   O_RX_HIGH_WATER,
	output logic                   O_RX_HIGH_LATCHED
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [1:0]                     ctrl_reg;
	logic [31:0]                    txlw_reg;
	logic [31:0]                    rxhw_reg;
	logic                           rx_lat_reg;
	logic                           t_ack_reg;
	logic [31:0]                    t_rdata_reg;
	logic                           tx_valid_reg;
	logic [31:0]                    tx_word_reg;
	logic                           tx_low_reg;
	logic                           rx_high_reg;
	logic                           pend_reg;
	logic [15:0]                    hold_reg;
	wuf_pkg::wuf_dma_t              state_reg;
	logic [1:0]                     idx_reg;
	logic [31:0]                    desc_ptr_reg;
	logic [31:0]                    buf_reg;
	logic [31:0]                    len_reg;
	logic [31:0]                    next_reg;
	logic                           m_req_reg;
	logic                           m_wr_reg;
	logic [31:0]                    m_addr_reg;
	logic [31:0]                    m_wdata_reg;
	logic                           acc;
	logic                           reg_wr;
	logic                           ptr_wr;
	logic                           port_pop;
	logic                           dma_pop;
	logic [31:0]                    tx_head;
	logic                           tx_empty;
	logic                           tx_full;
	logic [wuf_pkg::FIFO_AW:0]      tx_count;
	logic [31:0]                    rx_head;
	logic                           rx_empty;
	logic                           rx_full;
	logic [wuf_pkg::FIFO_AW:0]      rx_count;
	logic [31:0]                    pipe_head;
	logic                           pipe_empty;
	logic [wuf_pkg::PIPE_AW:0]      pipe_count;
	logic                           pipe_push;
	logic                           pipe_move;
	logic [31:0]                    pipe_word;
	logic [15:0]                    pix_field;
	logic [wuf_pkg::RX_CW-1:0]      rx_total;
	logic                           tx_load;

	// ----------------------------------------------------------------
	// access decode
	// ----------------------------------------------------------------
	assign acc      = link.t_req && !t_ack_reg;
	assign reg_wr   = acc && link.t_wr;
	assign ptr_wr   = reg_wr && (link.t_addr == wuf_pkg::REG_CHAIN);
	assign port_pop = acc && !link.t_wr && (link.t_addr == wuf_pkg::REG_PORT)
		&& !rx_empty;                                       // R22
	assign dma_pop  = (state_reg == wuf_pkg::DMA_DATA) && !m_req_reg && (len_reg != '0)
		&& !rx_empty && !port_pop;                          // R10
	assign rx_total = wuf_pkg::RX_CW'(rx_count) + wuf_pkg::RX_CW'(pipe_count); // R17 R8

	// ----------------------------------------------------------------
	// fifos
	// ----------------------------------------------------------------
	wuf_fifo #(.DEPTH(wuf_pkg::FIFO_DEPTH), .AW(wuf_pkg::FIFO_AW)) u_tx_fifo (
		.i_clk   (I_SYS_CLK),
		.i_reset (I_RESET),
		.i_push  (reg_wr && (link.t_addr == wuf_pkg::REG_PORT)),   // R9
		.i_data  (link.t_wdata),
		.i_pop   (tx_load),
		.o_data  (tx_head),
		.o_empty (tx_empty),
		.o_full  (tx_full),
		.o_count (tx_count)
	);

	wuf_fifo #(.DEPTH(wuf_pkg::PIPE_DEPTH), .AW(wuf_pkg::PIPE_AW)) u_rx_pipe (
		.i_clk   (I_SYS_CLK),
		.i_reset (I_RESET),
		.i_push  (pipe_push),
		.i_data  (pipe_word),
		.i_pop   (pipe_move),
		.o_data  (pipe_head),
		.o_empty (pipe_empty),
		.o_full  (),
		.o_count (pipe_count)
	);

	wuf_fifo #(.DEPTH(wuf_pkg::FIFO_DEPTH), .AW(wuf_pkg::FIFO_AW)) u_rx_fifo (
		.i_clk   (I_SYS_CLK),
		.i_reset (I_RESET),
		.i_push  (pipe_move),
		.i_data  (pipe_head),
		.i_pop   (port_pop || dma_pop),                     // R9 R10
		.o_data  (rx_head),
		.o_empty (rx_empty),
		.o_full  (rx_full),
		.o_count (rx_count)
	);

	// ----------------------------------------------------------------
	// receive packing
	// ----------------------------------------------------------------
	// marker sits in the top bit of each half, reserved bit reads zero
	assign pix_field = {I_RX_FRAME, 1'b0, I_RX_PIX};              // R11 R13
	assign pipe_word = ctrl_reg[wuf_pkg::CTRL_RX_SWAP] ?
		{hold_reg, pix_field} : {pix_field, hold_reg};               // R12
	assign pipe_push = I_RX_PIX_VALID && pend_reg;
	assign pipe_move = !pipe_empty && !rx_full;

	// first pixel of a pair waits in the hold register
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			pend_reg <= 1'b0;
			hold_reg <= '0;
		end else if (I_RX_PIX_VALID) begin
			pend_reg <= !pend_reg;
			hold_reg <= pix_field;
		end
	end

	// ----------------------------------------------------------------
	// transmit output stage
	// ----------------------------------------------------------------
	assign tx_load = !tx_empty && (!tx_valid_reg || I_TX_READY);

	// unused pixel bits are cleared on the way out
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			tx_valid_reg <= 1'b0;
			tx_word_reg  <= '0;
		end else if (tx_load) begin
			tx_valid_reg <= 1'b1;
			tx_word_reg  <= ctrl_reg[wuf_pkg::CTRL_TX_SWAP] ?                       // R12
				{2'b00, tx_head[wuf_pkg::PIX_W-1:0], 2'b00,
				tx_head[wuf_pkg::HALF_W +: wuf_pkg::PIX_W]} :
				{2'b00, tx_head[wuf_pkg::HALF_W +: wuf_pkg::PIX_W], 2'b00,
				tx_head[wuf_pkg::PIX_W-1:0]};                                      // R11
		end else if (I_TX_READY) begin
			tx_valid_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// water levels
	// ----------------------------------------------------------------
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			tx_low_reg  <= 1'b0;
			rx_high_reg <= 1'b0;
		end else begin
			tx_low_reg  <= tx_count < txlw_reg[wuf_pkg::FIFO_AW:0];        // R14 R15
			rx_high_reg <= rx_total >= rxhw_reg[wuf_pkg::RX_CW-1:0];      // R16 R15
		end
	end

	// sticky high water flag, a new event wins over the clear
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			rx_lat_reg <= 1'b0;
		end else if (rx_high_reg) begin
			rx_lat_reg <= 1'b1;                                            // R21
		end else if (reg_wr && (link.t_addr == wuf_pkg::REG_STAT)
			&& link.t_wdata[wuf_pkg::STAT_RX_LAT]) begin
			rx_lat_reg <= 1'b0;                                            // R21
		end
	end

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			ctrl_reg    <= '0;
			txlw_reg    <= wuf_pkg::WORD_ZERO;
			rxhw_reg    <= wuf_pkg::WORD_ZERO;
			t_ack_reg   <= 1'b0;
			t_rdata_reg <= wuf_pkg::WORD_ZERO;
		end else begin
			t_ack_reg <= acc;
			if (reg_wr) begin
				case (link.t_addr)
					wuf_pkg::REG_CTRL: ctrl_reg <= link.t_wdata[1:0];
					wuf_pkg::REG_TXLW: txlw_reg <= link.t_wdata;           // R15
					wuf_pkg::REG_RXHW: rxhw_reg <= link.t_wdata;
					default: ;
				endcase
			end else if (acc) begin
				case (link.t_addr)
					wuf_pkg::REG_CTRL:  t_rdata_reg <= {30'h0000_0000, ctrl_reg};
					wuf_pkg::REG_STAT:  t_rdata_reg <= {28'h000_0000,
						state_reg != wuf_pkg::DMA_IDLE, rx_lat_reg, rx_high_reg, tx_low_reg};
					wuf_pkg::REG_CHAIN: t_rdata_reg <= 32'(rx_total);     // R7
					wuf_pkg::REG_PORT:  t_rdata_reg <= rx_empty ? wuf_pkg::WORD_ZERO : rx_head;
					wuf_pkg::REG_TXLW:  t_rdata_reg <= txlw_reg;
					wuf_pkg::REG_RXHW:  t_rdata_reg <= rxhw_reg;
					default:            t_rdata_reg <= wuf_pkg::WORD_ZERO;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// receive chain dma
	// ----------------------------------------------------------------
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET || (ptr_wr && link.t_wdata == wuf_pkg::WORD_ZERO)) begin
			state_reg    <= wuf_pkg::DMA_IDLE;                     // R4
			idx_reg      <= '0;
			desc_ptr_reg <= wuf_pkg::WORD_ZERO;
			buf_reg      <= wuf_pkg::WORD_ZERO;
			len_reg      <= wuf_pkg::WORD_ZERO;
			next_reg     <= wuf_pkg::WORD_ZERO;
			m_req_reg    <= 1'b0;
			m_wr_reg     <= 1'b0;
			m_addr_reg   <= wuf_pkg::WORD_ZERO;
			m_wdata_reg  <= wuf_pkg::WORD_ZERO;
		end else if (ptr_wr) begin
			state_reg    <= wuf_pkg::DMA_FETCH;                    // R19
			idx_reg      <= '0;
			desc_ptr_reg <= {link.t_wdata[31:2], 2'b00};          // R18 R2
			m_req_reg    <= 1'b0;
		end else begin
			case (state_reg)
				wuf_pkg::DMA_FETCH: begin
					if (!m_req_reg) begin
						m_req_reg  <= 1'b1;
						m_wr_reg   <= 1'b0;
						m_addr_reg <= desc_ptr_reg + {28'h000_0000, idx_reg, 2'b00}; // R1
					end else if (link.m_ack) begin
						m_req_reg <= 1'b0;
						idx_reg   <= idx_reg + 1'b1;
						case (idx_reg)
							2'd0:    buf_reg  <= link.m_rdata;             // R20
							2'd1:    len_reg  <= link.m_rdata;             // R20
							default: begin
								next_reg  <= link.m_rdata;                 // R20
								state_reg <= wuf_pkg::DMA_DATA;
							end
						endcase
					end
				end
				wuf_pkg::DMA_DATA: begin
					if (dma_pop) begin
						m_req_reg   <= 1'b1;
						m_wr_reg    <= 1'b1;
						m_addr_reg  <= buf_reg;                        // R2
						m_wdata_reg <= rx_head;
					end else if (m_req_reg && link.m_ack) begin
						m_req_reg <= 1'b0;
						buf_reg   <= buf_reg + wuf_pkg::DESC_STEP;
						len_reg   <= len_reg - wuf_pkg::DESC_STEP;    // R3
					end else if (!m_req_reg && len_reg == wuf_pkg::WORD_ZERO) begin
						state_reg <= wuf_pkg::DMA_NEXT;
					end
				end
				wuf_pkg::DMA_NEXT: begin
					idx_reg      <= '0;
					desc_ptr_reg <= {next_reg[31:2], 2'b00};
					// stop on end of chain or a wrong direction bit
					state_reg <= (next_reg[wuf_pkg::PTR_EOC] || !next_reg[wuf_pkg::PTR_DIR]) ?
						wuf_pkg::DMA_IDLE : wuf_pkg::DMA_FETCH;      // R19 R6
				end
				default: state_reg <= wuf_pkg::DMA_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign link.t_ack         = t_ack_reg;
	assign link.t_rdata       = t_rdata_reg;
	assign link.m_req         = m_req_reg;
	assign link.m_wr          = m_wr_reg;
	assign link.m_addr        = m_addr_reg;
	assign link.m_wdata       = m_wdata_reg;
	assign O_TX_VALID         = tx_valid_reg;
	assign O_TX_WORD          = tx_word_reg;
	assign O_TX_LOW_WATER     = tx_low_reg;
	assign O_RX_HIGH_WATER    = rx_high_reg;
	assign O_RX_HIGH_LATCHED  = rx_lat_reg;
endmodule : wuf_device
`default_nettype wire

// *** hw/wuf_pkg.sv ***
/*
 * wuf_pkg: constants shared by both ends of the wide serial FIFO port.
 * Assumes: a single 200 MHz clock; 32-bit data words; the FIFO depth is a power of two.
 */
package wuf_pkg;
	// ----------------------------------------------------------------
	// device register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;  // pixel order control
	localparam logic [7:0] REG_STAT   = 8'h04;  // water levels, latch, dma busy
	localparam logic [7:0] REG_CHAIN  = 8'h0C;  // read: rx_words_held, write: receive_chain_pointer
	localparam logic [7:0] REG_PORT   = 8'h10;  // fifo_word_port
	localparam logic [7:0] REG_TXLW   = 8'h14;  // tx_low_water_threshold
	localparam logic [7:0] REG_RXHW   = 8'h18;  // rx_high_water_threshold

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_TX_SWAP = 0;
	localparam int CTRL_RX_SWAP = 1;
	localparam int STAT_TX_LOW  = 0;
	localparam int STAT_RX_HIGH = 1;
	localparam int STAT_RX_LAT  = 2;
	localparam int STAT_BUSY    = 3;
	localparam int PTR_EOC      = 0;
	localparam int PTR_DIR      = 1;
	localparam int PIX_W        = 14;
	localparam int HALF_W       = 16;

	// ----------------------------------------------------------------
	// sizes and reset values
	// ----------------------------------------------------------------
	localparam int FIFO_DEPTH  = 16;
	localparam int FIFO_AW     = 4;
	localparam int PIPE_DEPTH  = 4;
	localparam int PIPE_AW     = 2;
	localparam int RX_CW       = 6;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [31:0] DESC_STEP = 32'h0000_0004;

	// ----------------------------------------------------------------
	// host command registers (APB)
	// ----------------------------------------------------------------
	localparam logic [11:0] HREG_CMD   = 12'h000;  // [7:0] device offset, [8] write
	localparam logic [11:0] HREG_WDATA = 12'h004;
	localparam logic [11:0] HREG_RDATA = 12'h008;
	localparam logic [11:0] HREG_STAT  = 12'h00C;  // [0] busy
	localparam logic [11:0] HMEM_BASE  = 12'h100;  // 64 words of host memory
	localparam int CMD_WR_BIT = 8;
	localparam int HMEM_AW    = 6;

	typedef enum logic [3:0] {
		DMA_IDLE  = 4'b0001,
		DMA_FETCH = 4'b0010,
		DMA_DATA  = 4'b0100,
		DMA_NEXT  = 4'b1000
	} wuf_dma_t;
endpackage : wuf_pkg

// *** hw/wuf_link_if.sv ***
/*
 * wuf_link_if: link between the host end and the device end.
 * Assumes: both ends share one clock; each request is held until its ack pulse.
 */
`timescale 1ns/100ps
`default_nettype none
interface wuf_link_if;
	// target accesses, host to device registers
	logic        t_req;
	logic        t_wr;
	logic [7:0]  t_addr;
	logic [31:0] t_wdata;
	logic        t_ack;
	logic [31:0] t_rdata;
	// master accesses, device to host memory
	logic        m_req;
	logic        m_wr;
	logic [31:0] m_addr;
	logic [31:0] m_wdata;
	logic        m_ack;
	logic [31:0] m_rdata;

	modport dev (input t_req, t_wr, t_addr, t_wdata, m_ack, m_rdata,
		output t_ack, t_rdata, m_req, m_wr, m_addr, m_wdata);
	modport host (output t_req, t_wr, t_addr, t_wdata, m_ack, m_rdata,
		input t_ack, t_rdata, m_req, m_wr, m_addr, m_wdata);
endinterface : wuf_link_if
`default_nettype wire

// *** hw/wuf_fifo.sv ***
/*
 * wuf_fifo: first-word-fall-through FIFO of 32-bit words.
 * Assumes: DEPTH is 2**AW; push when full and pop when empty are ignored.
 */
`timescale 1ns/100ps
`default_nettype none
module wuf_fifo #(
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	input  wire logic          i_clk,
	input  wire logic          i_reset,
	input  wire logic          i_push,
	input  wire logic [31:0]   i_data,
	input  wire logic          i_pop,
	output logic      [31:0]   o_data,
	output logic               o_empty,
	output logic               o_full,
	output logic      [AW:0]   o_count
);
	logic [31:0]   mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0]   count_reg;
	logic          push_ok;
	logic          pop_ok;

	// flags and head word
	assign o_empty = (count_reg == '0);
	assign o_full  = (count_reg == (AW+1)'(DEPTH));
	assign o_count = count_reg;
	assign o_data  = mem[rd_ptr_reg];
	assign push_ok = i_push && !o_full;
	assign pop_ok  = i_pop && !o_empty;

	// storage
	always_ff @(posedge i_clk) begin
		if (push_ok) begin
			mem[wr_ptr_reg] <= i_data;
		end
	end

	// pointers and count; an empty pop moves nothing
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push_ok) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop_ok) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push_ok && !pop_ok) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop_ok && !push_ok) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule : wuf_fifo
`default_nettype wire

// *** hw/wuf_host.sv ***
/*
 * wuf_host: host end: APB command registers for device accesses and a small
 * host memory that answers the device's descriptor and data accesses.
 * Assumes: APB master keeps request stable until pready; one clock.
 */
`timescale 1ns/100ps
`default_nettype none
module wuf_host (
	input  wire logic              I_SYS_CLK,
	input  wire logic              I_RESET,
	wuf_link_if.host               link,
	input  wire logic              I_PSEL,
	input  wire logic              I_PENABLE,
	input  wire logic              I_PWRITE,
	input  wire logic [11:0]       I_PADDR,
	input  wire logic [31:0]       I_PWDATA,
	output logic      [31:0]       O_PRDATA,
	output logic                   O_PREADY
);
	logic [31:0]  mem [2**wuf_pkg::HMEM_AW];
	logic         pready_reg;
	logic [31:0]  prdata_reg;
	logic         t_req_reg;
	logic         t_wr_reg;
	logic [7:0]   t_addr_reg;
	logic [31:0]  t_wdata_reg;
	logic [31:0]  rdata_reg;
	logic         m_ack_reg;
	logic [31:0]  m_rdata_reg;
	logic         apb_do;
	logic         apb_mem;
	logic [wuf_pkg::HMEM_AW-1:0] apb_idx;

	// ----------------------------------------------------------------
	// apb decode: answer one cycle into the access phase
	// ----------------------------------------------------------------
	assign apb_do  = I_PSEL && I_PENABLE && pready_reg;
	assign apb_mem = I_PADDR >= wuf_pkg::HMEM_BASE;
	assign apb_idx = I_PADDR[wuf_pkg::HMEM_AW+1:2];

	// ready and read data
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			pready_reg <= 1'b0;
			prdata_reg <= wuf_pkg::WORD_ZERO;
		end else begin
			pready_reg <= I_PSEL && I_PENABLE && !pready_reg;
			if (apb_mem) begin
				prdata_reg <= mem[apb_idx];
			end else begin
				case (I_PADDR)
					wuf_pkg::HREG_WDATA: prdata_reg <= t_wdata_reg;
					wuf_pkg::HREG_RDATA: prdata_reg <= rdata_reg;
					wuf_pkg::HREG_STAT:  prdata_reg <= {31'h0000_0000, t_req_reg};
					default:             prdata_reg <= wuf_pkg::WORD_ZERO;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// device register access, held until the device acks
	// ----------------------------------------------------------------
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			t_req_reg   <= 1'b0;
			t_wr_reg    <= 1'b0;
			t_addr_reg  <= '0;
			t_wdata_reg <= wuf_pkg::WORD_ZERO;
			rdata_reg   <= wuf_pkg::WORD_ZERO;
		end else if (t_req_reg) begin
			if (link.t_ack) begin
				t_req_reg <= 1'b0;
				if (!t_wr_reg) begin
					rdata_reg <= link.t_rdata;
				end
			end
		end else if (apb_do && I_PWRITE && !apb_mem) begin
			case (I_PADDR)
				wuf_pkg::HREG_CMD: begin
					t_req_reg  <= 1'b1;
					t_wr_reg   <= I_PWDATA[wuf_pkg::CMD_WR_BIT];
					t_addr_reg <= I_PWDATA[7:0];
				end
				wuf_pkg::HREG_WDATA: t_wdata_reg <= I_PWDATA;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// host memory: software loads descriptors, device reads and writes
	// ----------------------------------------------------------------
	always_ff @(posedge I_SYS_CLK) begin
		if (apb_do && I_PWRITE && apb_mem) begin
			mem[apb_idx] <= I_PWDATA;
		end else if (link.m_req && !m_ack_reg && link.m_wr) begin
			mem[link.m_addr[wuf_pkg::HMEM_AW+1:2]] <= link.m_wdata;
		end
	end

	// one ack pulse per device request
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			m_ack_reg   <= 1'b0;
			m_rdata_reg <= wuf_pkg::WORD_ZERO;
		end else begin
			m_ack_reg   <= link.m_req && !m_ack_reg;
			m_rdata_reg <= mem[link.m_addr[wuf_pkg::HMEM_AW+1:2]];
		end
	end

	assign link.t_req   = t_req_reg;
	assign link.t_wr    = t_wr_reg;
	assign link.t_addr  = t_addr_reg;
	assign link.t_wdata = t_wdata_reg;
	assign link.m_ack   = m_ack_reg;
	assign link.m_rdata = m_rdata_reg;
	assign O_PRDATA     = prdata_reg;
	assign O_PREADY     = pready_reg;
endmodule : wuf_host
`default_nettype wire

// *** tb/wuf_link_monitor.sv ***
/*
 * wuf_link_monitor: concurrent checks on the link between host and device ends.
 * Assumes: one clock, synchronous active-high reset, signals taken from the interface.
 */
`timescale 1ns/100ps
`default_nettype none
module wuf_link_monitor (
	input  wire logic        I_SYS_CLK,
	input  wire logic        I_RESET,
	input  wire logic        t_req,
	input  wire logic        t_ack,
	input  wire logic        m_req,
	input  wire logic        m_ack,
	input  wire logic [31:0] m_addr
);
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RESET);
	// register access answered one cycle after it is taken
	a_tack_one_cycle: assert property (t_req && !t_ack |=> t_ack)
		else $error("register ack late");
	a_tack_single_pulse: assert property (t_ack |=> !t_ack)
		else $error("register ack too long");
	a_tack_has_cause: assert property (t_ack |-> $past(t_req))
		else $error("register ack without request");
	// memory requests held, dropped after answer, aligned
	a_mreq_held: assert property (m_req && !m_ack |=> m_req && $stable(m_addr))
		else $error("memory request not held");
	a_mreq_drops: assert property (m_ack |=> !m_req)
		else $error("memory request not dropped");
	a_mack_one_cycle: assert property (m_req && !m_ack |=> m_ack)
		else $error("memory ack late");
	a_mack_has_cause: assert property (m_ack |-> $past(m_req))
		else $error("memory ack without request");
	a_maddr_aligned: assert property (m_req |-> m_addr[1:0] == 2'b00)
		else $error("memory address unaligned");
endmodule : wuf_link_monitor
`default_nettype wire

// *** tb/wide_uart_fifo_port_and_rx_dma_tb.sv ***
/*
 * wide_uart_fifo_port_and_rx_dma_tb: both ends joined, driven over APB and pixel inputs.
 * Assumes: the package, interface and both design ends are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module wide_uart_fifo_port_and_rx_dma_tb;
	logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic        pv = 1'b0, pf = 1'b0, pready, txl, rxh, rxl;
	logic [11:0] pa = 12'h000;
	logic [13:0] pp = 14'h0000;
	logic [31:0] pwd = 32'h0000_0000, prdata, txw, rd;
	int          checks = 0, num_errors = 0, i;
	wuf_link_if wuf_link_if_inst ();
	wuf_device wuf_device_inst (.I_SYS_CLK(clk), .I_RESET(rst), .link(wuf_link_if_inst),
		.I_RX_PIX_VALID(pv), .I_RX_PIX(pp), .I_RX_FRAME(pf), .I_TX_READY(1'b0), .O_TX_VALID(),
		.O_TX_WORD(txw), .O_TX_LOW_WATER(txl), .O_RX_HIGH_WATER(rxh), .O_RX_HIGH_LATCHED(rxl));
	wuf_host wuf_host_inst (.I_SYS_CLK(clk), .I_RESET(rst), .link(wuf_link_if_inst),
		.I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd),
		.O_PRDATA(prdata), .O_PREADY(pready));
	wuf_link_monitor wuf_link_monitor_inst (.I_SYS_CLK(clk), .I_RESET(rst),
		.t_req(wuf_link_if_inst.t_req), .t_ack(wuf_link_if_inst.t_ack),
		.m_req(wuf_link_if_inst.m_req), .m_ack(wuf_link_if_inst.m_ack),
		.m_addr(wuf_link_if_inst.m_addr));
	always #2.5 clk = ~clk;
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	// one apb transfer, read data in rd
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk); psel <= 1'b1; pwr <= w; pa <= a; pwd <= d; pen <= 1'b0;
		@(posedge clk); pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
		if (n == 20) begin num_errors++; end_of_test(); end
		rd = prdata; psel <= 1'b0; pen <= 1'b0;
	endtask : apb
	// device register access via host command registers
	task automatic dev(input logic w, input logic [7:0] off, input logic [31:0] d);
		int n = 0;
		apb(1'b1, wuf_pkg::HREG_WDATA, d);
		apb(1'b1, wuf_pkg::HREG_CMD, {23'h0, w, off});
		do apb(1'b0, wuf_pkg::HREG_STAT, 32'h0000_0000); while (rd[0] !== 1'b0 && ++n < 20);
		if (n == 20) begin num_errors++; end_of_test(); end
		apb(1'b0, wuf_pkg::HREG_RDATA, 32'h0000_0000);
	endtask : dev
	task automatic pix(input logic [13:0] p, input logic f);
		@(posedge clk); pv <= 1'b1; pp <= p; pf <= f;
		@(posedge clk); pv <= 1'b0;
	endtask : pix
	// thresholds, low water, tx swap, dropped pixel bits
	task automatic t_tx;
		dev(1'b1, wuf_pkg::REG_TXLW, 32'hFFFF_FFE3);
		dev(1'b0, wuf_pkg::REG_TXLW, 32'h0000_0000);
		chk(rd, 32'hFFFF_FFE3, "tx threshold");
		chk({31'h0, txl}, 32'h0000_0001, "tx low empty");
		dev(1'b1, wuf_pkg::REG_CTRL, 32'h0000_0001);
		repeat (4) dev(1'b1, wuf_pkg::REG_PORT, 32'hC123_4567);
		chk({31'h0, txl}, 32'h0000_0000, "tx low at level");
		chk(txw, 32'h0567_0123, "tx word");
		$display("tx test done");
	endtask : t_tx
	// count, marker, pop, swap, latch, empty read
	task automatic t_rx;
		dev(1'b1, wuf_pkg::REG_RXHW, 32'h0000_0005);
		dev(1'b1, wuf_pkg::REG_STAT, 32'h0000_0004);
		chk({31'h0, rxl}, 32'h0000_0000, "unlatch");
		pix(14'h1234, 1'b0); pix(14'h0ABC, 1'b1);
		repeat (4) pix(14'h0001, 1'b0);
		repeat (10) @(posedge clk);
		dev(1'b0, wuf_pkg::REG_CHAIN, 32'h0000_0000); chk(rd, 32'h0000_0003, "rx count");
		chk({31'h0, rxh}, 32'h0000_0000, "rx high below");
		dev(1'b0, wuf_pkg::REG_PORT, 32'h0000_0000); chk(rd, 32'h8ABC_1234, "rx word");
		dev(1'b0, wuf_pkg::REG_CHAIN, 32'h0000_0000); chk(rd, 32'h0000_0002, "rx after pop");
		dev(1'b1, wuf_pkg::REG_CTRL, 32'h0000_0002);
		repeat (3) begin pix(14'h0002, 1'b0); pix(14'h0001, 1'b0); end
		repeat (10) @(posedge clk);
		chk({31'h0, rxh}, 32'h0000_0001, "rx high at level");
		chk({31'h0, rxl}, 32'h0000_0001, "rx latched");
		for (i = 0; i < 6; i++) begin
			dev(1'b0, wuf_pkg::REG_PORT, 32'h0000_0000);
			chk(rd, (i < 2) ? 32'h0001_0001 : (i < 5) ? 32'h0002_0001 : 32'h0000_0000, "drain");
		end
		dev(1'b0, wuf_pkg::REG_CHAIN, 32'h0000_0000); chk(rd, 32'h0000_0000, "empty");
		$display("rx test done");
	endtask : t_rx
	// one chain moves two words to host memory
	task automatic t_dma;
		int n = 0;
		apb(1'b1, 12'h100, 32'h0000_0040);
		apb(1'b1, 12'h104, 32'h0000_0008);
		apb(1'b1, 12'h108, 32'h0000_0003);
		for (i = 1; i < 5; i++) pix(i[13:0], 1'b0);
		repeat (10) @(posedge clk);
		dev(1'b1, wuf_pkg::REG_CHAIN, 32'h0000_0002);
		do dev(1'b0, wuf_pkg::REG_STAT, 32'h0000_0000); while (rd[3] !== 1'b0 && ++n < 40);
		if (n == 40) begin num_errors++; end_of_test(); end
		apb(1'b0, 12'h140, 32'h0000_0000); chk(rd, 32'h0001_0002, "dma word 0");
		apb(1'b0, 12'h144, 32'h0000_0000); chk(rd, 32'h0003_0004, "dma word 1");
		dev(1'b0, wuf_pkg::REG_CHAIN, 32'h0000_0000); chk(rd, 32'h0000_0000, "dma drained");
		$display("dma test done");
	endtask : t_dma
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_tx();
		t_rx();
		t_dma();
		end_of_test();
	end
endmodule : wide_uart_fifo_port_and_rx_dma_tb
`default_nettype wire
